// [core/fdc_addr_reg.sv]
// Purpose: Read-side address of one descriptor, advancing by a word per beat.
// Assumes: Beats arrive only while the descriptor is valid.
// Notes: Writes are ignored while locked so software cannot disturb a live transfer.
`timescale 1ns/1ps
`include "fdc_regs.svh"
module fdc_addr_reg
  import fdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wr_i,
  input wire fdc_word_t wdata_i,
  input wire logic lock_i,
  input wire logic beat_i,
  output fdc_word_t addr_o
);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_o <= `FDC_ADDR_RESET;
    end else if (ce_i) begin
      if (wr_i && !lock_i) begin
        // The two low bits are masked so a transfer always starts word aligned.
        addr_o <= {wdata_i[31:2], 2'b00};
      end else if (beat_i && lock_i) begin
        addr_o <= addr_o + `FDC_ADDR_STEP;
      end
    end
  end

  chk_addr_advance: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && beat_i && lock_i |=> addr_o == $past(addr_o) + 32'h00000004)
    else $error("read address did not advance by one word");
  chk_addr_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ce_i || !beat_i) && lock_i |=> addr_o == $past(addr_o))
    else $error("read address changed while locked and idle");
endmodule // fdc_addr_reg

// [core/fdc_desc_flags.sv]
// Purpose: Valid bit and three sticky status flags of one descriptor.
// Assumes: Event inputs are single-cycle pulses on clk_i.
// Notes: A set event wins over any clear in the same cycle, except for the valid bit, where a clear or end wins over valid set.
`timescale 1ns/1ps
module fdc_desc_flags
  import fdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic valid_set_i,
  input wire logic desc_clr_i,
  input wire logic misal_set_i,
  input wire logic misal_clr_i,
  input wire logic xfr_clr_i,
  input wire logic bus_err_i,
  input wire logic xfer_end_i,
  output logic valid_o,
  output logic misal_o,
  output logic err_o,
  output logic done_o
);
  logic next_valid;
  always_comb begin
    next_valid = valid_o;
    if (desc_clr_i) begin
      next_valid = 1'b0;
    end else if (valid_o && xfer_end_i) begin
      next_valid = 1'b0;
    end else if (valid_set_i) begin
      next_valid = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
    end else if (ce_i) begin
      valid_o <= next_valid;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      misal_o <= 1'b0;
    end else if (ce_i) begin
      misal_o <= misal_set_i | (misal_o & ~(misal_clr_i | valid_set_i | desc_clr_i));
    end
  end

  // Errors and completions only count while the descriptor owns a transfer.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      err_o <= 1'b0;
    end else if (ce_i) begin
      err_o <= (bus_err_i & valid_o) | (err_o & ~(xfr_clr_i | valid_set_i));
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= (xfer_end_i & valid_o) | (done_o & ~(xfr_clr_i | valid_set_i));
    end
  end

  chk_misal_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && misal_clr_i && !misal_set_i |=> !misal_o)
    else $error("misalign flag not cleared");
  chk_err_set: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && bus_err_i && valid_o |=> err_o && !valid_o || err_o)
    else $error("transfer error flag not set");
  chk_err_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && xfr_clr_i && !(bus_err_i && valid_o) |=> !err_o)
    else $error("transfer error flag not cleared");
  chk_done_end: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && xfer_end_i && valid_o && !desc_clr_i |=> done_o && !valid_o)
    else $error("end did not set done and free descriptor");
  chk_done_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && valid_set_i && !valid_o && !desc_clr_i |=> !done_o && !err_o && valid_o)
    else $error("valid set did not discard old status");
  cov_error_end: cover property (@(posedge clk_i) disable iff (rst_i)
    err_o && done_o);
endmodule // fdc_desc_flags

// [core/fdc_pkg.sv]
// Purpose: Shared types of the descriptor status block.
// Assumes: Four descriptors.
// Notes: Numeric constants live in fdc_regs.svh.
package fdc_pkg;
  typedef logic [31:0] fdc_word_t;
  typedef logic [15:0] fdc_size_t;
  typedef logic [13:0] fdc_words_t;
endpackage

// [core/fdc_regs.svh]
// Purpose: Register offsets, field positions and reset values of the descriptor status block.
// Assumes: Offsets are byte addresses decoded on the seven low address bits.
// Notes: Definitions only.
`ifndef FDC_REGS_SVH
`define FDC_REGS_SVH
`define FDC_ADDR_BITS 7
`define FDC_EDR_OFF 7'h00
`define FDC_SAR0_OFF 7'h04
`define FDC_CR0_OFF 7'h0c
`define FDC_DESC_STRIDE 7'h14
`define FDC_ICR_OFF 7'h54
`define FDC_EDR_EMPTY_LSB 0
`define FDC_EDR_DONE_LSB 4
`define FDC_EDR_ERR_LSB 8
`define FDC_EDR_MISAL_LSB 12
`define FDC_EDR_RESET 32'h0000000f
`define FDC_CR_VALID_BIT 16
`define FDC_CR_CLR_BIT 18
`define FDC_ICR_XFR_LSB 0
`define FDC_ICR_MISAL_LSB 4
`define FDC_ADDR_RESET 32'h00000000
`define FDC_ADDR_STEP 32'h00000004
`endif

// [core/fdc_status.sv]
// Purpose: Descriptor status flags and read-side addresses of a four-descriptor DMA.
// Assumes: APB slave decoded on paddr[6:0]; engine event pulses share clk_i.
// Notes: Status reads have no side effects.
// Function
// - Misalign flag per descriptor, bits 15..12, set for byte count not multiple of four.
// - Misalign flag cleared by its clear bit, by valid set, or by descriptor clear.
// - Misaligned count never aborts; two low count bits are ignored.
// - Error flag, bits 11..8, set on a bus error during that transfer.
// - Error flag cleared by transfer clear bit or by valid set.
// - Done flag, bits 7..4, set when transfer ends, normally or with error.
// - Done flag cleared by transfer clear bit or by valid set.
// - Empty flags, bits 3..0, reset to one: descriptor free.
// - Empty flag low while the descriptor is queued or running.
// - Empty flag returns high when the transfer finishes.
// - Each descriptor holds a 32-bit read start address, reset zero.
// - Status register is read-only at offset zero, reset shows all empty.
// - Setting valid discards prior completion and error status.
// - Only the seven low address bits are decoded.
// - Read address advances after each successful beat.
`timescale 1ns/1ps
`include "fdc_regs.svh"
module fdc_status
  import fdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire fdc_word_t pwdata_i,
  output fdc_word_t prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [3:0] beat_i,
  input wire logic [3:0] bus_err_i,
  input wire logic [3:0] xfer_end_i,
  output logic [3:0] desc_valid_o,
  output fdc_words_t [3:0] desc_words_o,
  output fdc_word_t [3:0] desc_read_addr_o
);
  logic [`FDC_ADDR_BITS-1:0] addr;
  logic wr_en;
  logic icr_wr;
  logic [3:0] misal;
  logic [3:0] err;
  logic [3:0] done;
  logic [3:0] sar_hit;
  logic [3:0] cr_hit;
  logic [3:0] cr_wr_ok;
  logic [3:0] valid_set;
  logic [3:0] desc_clr;
  logic [3:0] misal_set;
  fdc_size_t [3:0] size;
  fdc_word_t status_word;
  fdc_word_t next_rdata;

  assign addr = paddr_i[`FDC_ADDR_BITS-1:0];
  assign wr_en = ce_i && psel_i && penable_i && pwrite_i;
  assign icr_wr = wr_en && (addr == `FDC_ICR_OFF);
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;

  // Upper half reads as zero; software is expected to write it back unchanged.
  assign status_word = {16'h0000, misal, err, done, ~desc_valid_o};

  genvar d;
  generate
    for (d = 0; d < 4; d++) begin : g_desc
      assign sar_hit[d] = addr == 7'(`FDC_SAR0_OFF + d * `FDC_DESC_STRIDE);
      assign cr_hit[d] = addr == 7'(`FDC_CR0_OFF + d * `FDC_DESC_STRIDE);
      assign desc_clr[d] = wr_en && cr_hit[d] && pwdata_i[`FDC_CR_CLR_BIT];
      // A live descriptor locks its fields; only the clear bit still acts.
      assign cr_wr_ok[d] = wr_en && cr_hit[d] && !desc_valid_o[d] && !desc_clr[d];
      assign valid_set[d] = cr_wr_ok[d] && pwdata_i[`FDC_CR_VALID_BIT];
      assign misal_set[d] = cr_wr_ok[d] && (pwdata_i[1:0] != 2'b00);
      // The engine moves whole words only, so the low count bits drop out.
      assign desc_words_o[d] = size[d][15:2];

      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          size[d] <= 16'h0000;
        end else if (ce_i) begin
          if (desc_clr[d]) begin
            size[d] <= 16'h0000;
          end else if (cr_wr_ok[d]) begin
            size[d] <= pwdata_i[15:0];
          end
        end
      end

      fdc_desc_flags u_flags (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .valid_set_i(valid_set[d]),
        .desc_clr_i(desc_clr[d]),
        .misal_set_i(misal_set[d]),
        .misal_clr_i(icr_wr && pwdata_i[`FDC_ICR_MISAL_LSB + d]),
        .xfr_clr_i(icr_wr && pwdata_i[`FDC_ICR_XFR_LSB + d]),
        .bus_err_i(bus_err_i[d]),
        .xfer_end_i(xfer_end_i[d]),
        .valid_o(desc_valid_o[d]),
        .misal_o(misal[d]),
        .err_o(err[d]),
        .done_o(done[d])
      );

      fdc_addr_reg u_addr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .wr_i(wr_en && sar_hit[d]),
        .wdata_i(pwdata_i),
        .lock_i(desc_valid_o[d]),
        .beat_i(beat_i[d]),
        .addr_o(desc_read_addr_o[d])
      );

      chk_misal_set: assert property (@(posedge clk_i) disable iff (rst_i)
        misal_set[d] |=> misal[d] && desc_valid_o[d] == $past(pwdata_i[`FDC_CR_VALID_BIT]))
        else $error("misaligned count did not raise flag");
      chk_misal_runs: assert property (@(posedge clk_i) disable iff (rst_i)
        valid_set[d] && pwdata_i[1:0] != 2'b00 |=> desc_valid_o[d]
          && desc_words_o[d] == $past(pwdata_i[15:2]))
        else $error("misaligned descriptor did not start");
      chk_empty_return: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && desc_valid_o[d] && xfer_end_i[d] && !desc_clr[d]
          |=> status_word[`FDC_EDR_EMPTY_LSB + d] && status_word[`FDC_EDR_DONE_LSB + d])
        else $error("empty flag not restored at transfer end");
      cov_misal: cover property (@(posedge clk_i) disable iff (rst_i)
        misal[d] && desc_valid_o[d]);
      cov_done: cover property (@(posedge clk_i) disable iff (rst_i)
        done[d] && !err[d]);
    end
  endgenerate

  always_comb begin
    next_rdata = 32'h00000000;
    if (addr == `FDC_EDR_OFF) begin
      next_rdata = status_word;
    end
    for (int i = 0; i < 4; i++) begin
      if (sar_hit[i]) begin
        next_rdata = desc_read_addr_o[i];
      end
      if (cr_hit[i]) begin
        next_rdata = {15'h0000, desc_valid_o[i], size[i]};
      end
    end
  end

  // Read data is captured in the setup phase so it stands during the access phase.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h00000000;
    end else if (ce_i && psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= next_rdata;
    end
  end

  chk_status_reset: assert property (@(posedge clk_i)
    $fell(rst_i) |-> status_word == `FDC_EDR_RESET)
    else $error("status reset value wrong");
  chk_status_upper: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && psel_i && !penable_i && !pwrite_i && addr == `FDC_EDR_OFF
      |=> prdata_o[31:16] == 16'h0000 && prdata_o[15:0] == $past(status_word[15:0]))
    else $error("status read returned wrong value");
  chk_read_pure: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && psel_i && !pwrite_i && beat_i == 4'h0 && bus_err_i == 4'h0 && xfer_end_i == 4'h0
      |=> status_word == $past(status_word))
    else $error("status changed on a read");
  chk_ce_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> status_word == $past(status_word) && desc_read_addr_o == $past(desc_read_addr_o))
    else $error("state moved while clock enable low");
  cov_err_all: cover property (@(posedge clk_i) disable iff (rst_i) err == 4'hf);
endmodule // fdc_status

// [verification/dma_descriptor_status_flags_tb_top.sv]
// Purpose: Self-checking bench for the descriptor status block.
// Assumes: Engine model drives the event pulses; APB accesses take two cycles.
// Notes: Writes leave the upper status bits as read.
`timescale 1ns/1ps
module dma_descriptor_status_flags_tb_top
  import fdc_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic ce = 1'b1;
  logic [31:0] paddr = '0;
  fdc_word_t pwdata = '0, prdata, rd;
  logic pready, pslverr;
  logic [3:0] beat, berr, xend, valid, fail = '0;
  fdc_words_t [3:0] words;
  fdc_word_t [3:0] raddr;
  int errors = 0, compares = 0, cyc = 0;
  fdc_status dut_u (.clk_i(clk), .rst_i(rst), .ce_i(ce), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .beat_i(beat), .bus_err_i(berr),
    .xfer_end_i(xend), .desc_valid_o(valid), .desc_words_o(words), .desc_read_addr_o(raddr));
  fdc_engine_model eng_u (.clk_i(clk), .rst_i(rst), .slow_i(slow), .fail_i(fail),
    .desc_valid_i(valid), .desc_words_i(words), .beat_o(beat), .bus_err_o(berr),
    .xfer_end_o(xend));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // A hang must end in the same report as a normal run.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic chk(input string what, input fdc_word_t exp, input fdc_word_t got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input fdc_word_t d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    rd = prdata;
    chk("pready", 32'h1, {31'h0, pready});
    chk("pslverr", 32'h0, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input string what, input logic [31:0] a, input fdc_word_t exp);
    apb(1'b0, a, '0);
    chk(what, exp, rd);
  endtask
  task automatic wait_free(input int d);
    for (int n = 0; n < 300 && valid[d] !== 1'b0; n++) @(posedge clk);
  endtask
  task automatic t_reset_map();
    rd_chk("status", 32'h0, 32'h0000000f);
    rd_chk("status again", 32'h0, 32'h0000000f);
    for (int d = 0; d < 3; d++) rd_chk("sar", 32'h4 + 32'h14 * d, 32'h0);
    apb(1'b1, 32'h0, {rd[31:16], 16'hffff});
    rd_chk("status ro", 32'h0, 32'h0000000f);
    for (int d = 0; d < 3; d++) apb(1'b1, 32'h4 + 32'h14 * d, 32'h89abcde7 + 32'h10 * d);
    for (int d = 0; d < 3; d++)
      rd_chk("sar", 32'h4 + 32'h14 * d, 32'h89abcde4 + 32'h10 * d);
    rd_chk("alias", 32'h12345f84, 32'h89abcde4);
    rd_chk("unmapped", 32'h7c, 32'h0);
  endtask
  task automatic t_run();
    slow <= 1'b1;
    apb(1'b1, 32'h4, 32'h00000100);
    apb(1'b1, 32'h0c, 32'h00010065);
    rd_chk("running", 32'h0, 32'h0000100e);
    wait_free(0);
    chk("words", 32'h19, {18'h0, words[0]});
    rd_chk("addr end", 32'h4, 32'h00000164);
    rd_chk("done", 32'h0, 32'h0000101f);
    apb(1'b1, 32'h54, 32'h00000001);
    rd_chk("xfr clr", 32'h0, 32'h0000100f);
    apb(1'b1, 32'h54, 32'h00000010);
    rd_chk("misal clr", 32'h0, 32'h0000000f);
  endtask
  task automatic t_err_revalid();
    slow <= 1'b0;
    fail <= 4'h2;
    apb(1'b1, 32'h20, 32'h00010008);
    wait_free(1);
    fail <= 4'h0;
    rd_chk("error", 32'h0, 32'h0000022f);
    slow <= 1'b1;
    apb(1'b1, 32'h20, 32'h00010041);
    rd_chk("revalid", 32'h0, 32'h0000200d);
    apb(1'b1, 32'h20, 32'h00040000);
    chk("valid", 32'h0, {31'h0, valid[1]});
    rd_chk("desc clr", 32'h0, 32'h0000000f);
    apb(1'b1, 32'h54, 32'h000000ff);
    rd_chk("idle", 32'h0, 32'h0000000f);
  endtask
  // Clock enable low must swallow a write; a mid-run reset must restore the valid bits, the status word and the descriptor 1 read address.
  task automatic t_freeze_reset();
    apb(1'b1, 32'h18, 32'h00000200);
    chk("raddr", 32'h00000200, raddr[1]);
    ce <= 1'b0;
    apb(1'b1, 32'h18, 32'h00000300);
    chk("frozen", 32'h00000200, raddr[1]);
    ce <= 1'b1;
    apb(1'b1, 32'h0c, 32'h00010008);
    chk("started", 32'h1, {31'h0, valid[0]});
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("valid reset", 32'h0, {28'h0, valid});
    rd_chk("status reset", 32'h0, 32'h0000000f);
    rd_chk("sar reset", 32'h18, 32'h0);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset_map();
    t_run();
    t_err_revalid();
    t_freeze_reset();
    end_of_test();
  end
endmodule // dma_descriptor_status_flags_tb_top

// [verification/fdc_engine_model.sv]
// Purpose: Behavioural data mover that feeds beat, error and end pulses to the status block.
// Assumes: One word moves per beat; a commanded failure ends the transfer at once.
// Notes: slow_i halves the beat rate so software can observe a running descriptor.
`timescale 1ns/1ps
module fdc_engine_model
  import fdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic [3:0] fail_i,
  input wire logic [3:0] desc_valid_i,
  input wire fdc_words_t [3:0] desc_words_i,
  output logic [3:0] beat_o,
  output logic [3:0] bus_err_o,
  output logic [3:0] xfer_end_o
);
  fdc_words_t cnt [4];
  logic [3:0] fin;
  logic tick;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      beat_o <= '0;
      bus_err_o <= '0;
      xfer_end_o <= '0;
      fin <= '0;
      tick <= 1'b0;
      for (int d = 0; d < 4; d++) cnt[d] <= '0;
    end else begin
      tick <= ~tick;
      for (int d = 0; d < 4; d++) begin
        beat_o[d] <= 1'b0;
        bus_err_o[d] <= 1'b0;
        xfer_end_o[d] <= 1'b0;
        // Finished descriptors stay silent until software revalidates them.
        if (!desc_valid_i[d]) begin
          cnt[d] <= '0;
          fin[d] <= 1'b0;
        end else if (!fin[d] && (!slow_i || tick)) begin
          if (cnt[d] == desc_words_i[d] || fail_i[d]) begin
            bus_err_o[d] <= fail_i[d];
            xfer_end_o[d] <= 1'b1;
            fin[d] <= 1'b1;
          end else begin
            beat_o[d] <= 1'b1;
            cnt[d] <= cnt[d] + 14'h1;
          end
        end
      end
    end
  end
endmodule // fdc_engine_model
